/* File: src/elop_defines.vh */
/*
 event link option and port group: register offsets, field positions, reset values
 and encodings. assumes word-aligned wishbone access, byte address = 4 * index.
*/
`ifndef ELOP_DEFINES_VH
`define ELOP_DEFINES_VH

// offsets are word-aligned, so they are kept as word indices
`define ELOP_IDX_OPT_A 32'h0008B11F
`define ELOP_IDX_OPT_B 32'h0008B120
`define ELOP_IDX_OPT_C 32'h0008B121
`define ELOP_IDX_OPT_D 32'h0008B122
`define ELOP_IDX_MEMBER 32'h0008B123
`define ELOP_IDX_GCTRL 32'h0008B125
`define ELOP_IDX_PBUF 32'h0008B127
// own register: port direction and port output data
`define ELOP_IDX_PDIR 32'h0008B130
`define ELOP_IDX_POUT 32'h0008B131

// reserved bits read as one
`define ELOP_RSV_A 8'h03
`define ELOP_RSV_B 8'hFC
`define ELOP_RSV_C 8'hC3
`define ELOP_RSV_D 8'hCC
`define ELOP_RSV_GC 8'h88

// reset: all timer responses disabled
`define ELOP_RST_OPT 8'hFF
`define ELOP_RST_GC 8'h88

`define ELOP_MD_START 2'h0
`define ELOP_MD_RESTART 2'h1
`define ELOP_MD_CAPCNT 2'h2
`define ELOP_MD_OFF 2'h3

`define ELOP_GC_EDGE_LSB 0
`define ELOP_GC_OVE_BIT 2
`define ELOP_GC_ACT_LSB 4

`define ELOP_ACT_LOW 3'h0
`define ELOP_ACT_HIGH 3'h1
`define ELOP_ACT_TOGGLE 3'h2
`define ELOP_ACT_BUFFER 3'h3

`endif

/* File: src/elop_edge_det.v */
/*
 edge detector for the input port group; raises one pulse for each cycle with a selected edge on any
 member pin. assumes pins are synchronous to clk_i.
*/
`timescale 1ns/1ps

module elop_edge_det
#(
    parameter WIDTH = 8
)
(
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] pin_i,
    input wire [WIDTH-1:0] en_i,
    input wire [1:0] edge_sel_i,
    output reg evt_o
);

    reg [WIDTH-1:0] prev_r;
    wire [WIDTH-1:0] rise;
    wire [WIDTH-1:0] fall;
    reg hit;

    assign rise = pin_i & ~prev_r & en_i;
    assign fall = ~pin_i & prev_r & en_i;

    always @*
    begin
        if (edge_sel_i[1])
            hit = |(rise | fall);
        else if (edge_sel_i[0])
            hit = |fall;
        else
            hit = |rise;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_r <= {WIDTH{1'b0}};
            evt_o <= 1'b0;
        end
        else
        begin
            prev_r <= pin_i;
            // only pins enabled this cycle count, so a freshly added pin cannot fire falsely
            evt_o <= hit;
        end
    end

endmodule

/* File: src/elop_timer_act.v */
/*
 decodes one 2-bit timer mode field into one-cycle action strobes on an event.
 assumes evt_i is already a single-cycle pulse and run_i is the timer's start bit.
*/
`timescale 1ns/1ps
`include "elop_defines.vh"

module elop_timer_act
(
    input wire clk_i,
    input wire rst_i,
    input wire [1:0] mode_i,
    input wire evt_i,
    input wire run_i,
    output reg start_o,
    output reg restart_o,
    output reg capcnt_o
);

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_o <= 1'b0;
            restart_o <= 1'b0;
            capcnt_o <= 1'b0;
        end
        else
        begin
            // a start event while already running is dropped
            start_o <= evt_i && (mode_i == `ELOP_MD_START) && !run_i;
            restart_o <= evt_i && (mode_i == `ELOP_MD_RESTART);
            capcnt_o <= evt_i && (mode_i == `ELOP_MD_CAPCNT);
        end
    end

endmodule

/* File: src/elop_top.v */
/*
 event link option registers and port B group logic with a wishbone classic slave.
 assumes events arrive as one-cycle pulses on clk_i and port pins are synchronous.
*/
`timescale 1ns/1ps
`include "elop_defines.vh"

module elop_top
#(
    parameter PW = 8
)
(
    input wire clk_i,
    input wire rst_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    input wire [3:0] mft_evt_i,
    input wire [3:0] mft_run_i,
    input wire cmt_evt_i,
    input wire cmt_run_i,
    input wire lowpwr_evt_i,
    input wire [1:0] bt_evt_i,
    input wire [1:0] bt_run_i,
    input wire grp_out_evt_i,
    input wire grp_in_evt_i,
    input wire [PW-1:0] port_pin_i,
    output reg [3:0] mft_start_o,
    output reg [3:0] mft_restart_o,
    output reg [3:0] mft_capture_o,
    output reg cmt_start_o,
    output reg cmt_restart_o,
    output reg cmt_count_o,
    output reg lowpwr_irq_o,
    output reg [1:0] bt_start_o,
    output reg [1:0] bt_restart_o,
    output reg [1:0] bt_count_o,
    output reg [PW-1:0] port_output_data_o,
    output reg [PW-1:0] port_direction_o,
    output reg grp_in_evt_o
);

    reg [7:0] opt_a_r;
    reg [7:0] opt_b_r;
    reg [7:0] opt_c_r;
    reg [7:0] opt_d_r;
    reg [PW-1:0] member_r;
    reg [7:0] gctrl_r;
    reg [PW-1:0] pbuf_r;
    reg [PW-1:0] pbuf_nxt;
    reg [PW-1:0] pout_nxt;

    wire [29:0] idx;
    wire req;
    reg [31:0] rd;
    reg hit;
    wire wr;

    wire [1:0] mft_ch1_mode;
    wire [1:0] mft_ch2_mode;
    wire [1:0] mft_ch3_mode;
    wire [1:0] mft_ch4_mode;
    wire [1:0] cmpmatch_timer_mode;
    wire [1:0] lowpower_timer_mode;
    wire [1:0] byte_timer0_mode;
    wire [1:0] byte_timer2_mode;
    wire [1:0] group_edge_select;
    wire buffer_overwrite_enable;
    wire [2:0] group_output_action;
    wire [PW-1:0] in_members;
    wire [PW-1:0] out_members;
    wire [3:0] mft_s;
    wire [3:0] mft_rs;
    wire [3:0] mft_c;
    wire [1:0] bt_s;
    wire [1:0] bt_rs;
    wire [1:0] bt_c;
    wire cmt_s;
    wire cmt_rs;
    wire cmt_c;
    wire edge_evt;

    // replace the old value with the byte written on lane 0, forcing reserved bits back to one
    function [7:0] wr_byte;
        input [7:0] old;
        input [7:0] val;
        input [7:0] rsv;
        begin
            wr_byte = val | rsv;
            wr_byte = wr_byte | (old & 8'h00);
        end
    endfunction

    assign mft_ch1_mode = opt_a_r[3:2];
    assign mft_ch2_mode = opt_a_r[5:4];
    assign mft_ch3_mode = opt_a_r[7:6];
    assign mft_ch4_mode = opt_b_r[1:0];
    assign cmpmatch_timer_mode = opt_c_r[3:2];
    assign lowpower_timer_mode = opt_c_r[5:4];
    assign byte_timer0_mode = opt_d_r[1:0];
    assign byte_timer2_mode = opt_d_r[5:4];
    assign group_edge_select = gctrl_r[`ELOP_GC_EDGE_LSB+1:`ELOP_GC_EDGE_LSB];
    assign buffer_overwrite_enable = gctrl_r[`ELOP_GC_OVE_BIT];
    assign group_output_action = gctrl_r[`ELOP_GC_ACT_LSB+2:`ELOP_GC_ACT_LSB];
    // direction bit 1 = output, as in the port direction register
    assign in_members = member_r & ~port_direction_o;
    assign out_members = member_r & port_direction_o;

    elop_timer_act u_mft1 (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mft_ch1_mode),
        .evt_i(mft_evt_i[0]), .run_i(mft_run_i[0]), .start_o(mft_s[0]),
        .restart_o(mft_rs[0]), .capcnt_o(mft_c[0]));
    elop_timer_act u_mft2 (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mft_ch2_mode),
        .evt_i(mft_evt_i[1]), .run_i(mft_run_i[1]), .start_o(mft_s[1]),
        .restart_o(mft_rs[1]), .capcnt_o(mft_c[1]));
    elop_timer_act u_mft3 (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mft_ch3_mode),
        .evt_i(mft_evt_i[2]), .run_i(mft_run_i[2]), .start_o(mft_s[2]),
        .restart_o(mft_rs[2]), .capcnt_o(mft_c[2]));
    elop_timer_act u_mft4 (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mft_ch4_mode),
        .evt_i(mft_evt_i[3]), .run_i(mft_run_i[3]), .start_o(mft_s[3]),
        .restart_o(mft_rs[3]), .capcnt_o(mft_c[3]));
    elop_timer_act u_cmt (.clk_i(clk_i), .rst_i(rst_i), .mode_i(cmpmatch_timer_mode),
        .evt_i(cmt_evt_i), .run_i(cmt_run_i), .start_o(cmt_s),
        .restart_o(cmt_rs), .capcnt_o(cmt_c));
    elop_timer_act u_bt0 (.clk_i(clk_i), .rst_i(rst_i), .mode_i(byte_timer0_mode),
        .evt_i(bt_evt_i[0]), .run_i(bt_run_i[0]), .start_o(bt_s[0]),
        .restart_o(bt_rs[0]), .capcnt_o(bt_c[0]));
    elop_timer_act u_bt2 (.clk_i(clk_i), .rst_i(rst_i), .mode_i(byte_timer2_mode),
        .evt_i(bt_evt_i[1]), .run_i(bt_run_i[1]), .start_o(bt_s[1]),
        .restart_o(bt_rs[1]), .capcnt_o(bt_c[1]));

    elop_edge_det #(.WIDTH(PW)) u_edge (.clk_i(clk_i), .rst_i(rst_i),
        .pin_i(port_pin_i), .en_i(in_members), .edge_sel_i(group_edge_select),
        .evt_o(edge_evt));

    // timer strobes pass one more flop so every top output is registered
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mft_start_o <= 4'h0;
            mft_restart_o <= 4'h0;
            mft_capture_o <= 4'h0;
            cmt_start_o <= 1'b0;
            cmt_restart_o <= 1'b0;
            cmt_count_o <= 1'b0;
            bt_start_o <= 2'h0;
            bt_restart_o <= 2'h0;
            bt_count_o <= 2'h0;
            lowpwr_irq_o <= 1'b0;
            grp_in_evt_o <= 1'b0;
        end
        else
        begin
            mft_start_o <= mft_s;
            mft_restart_o <= mft_rs;
            mft_capture_o <= mft_c;
            cmt_start_o <= cmt_s;
            cmt_restart_o <= cmt_rs;
            cmt_count_o <= cmt_c;
            bt_start_o <= bt_s;
            bt_restart_o <= bt_rs;
            bt_count_o <= bt_c;
            // prohibited codes 01/10 are treated as blocked
            lowpwr_irq_o <= lowpwr_evt_i && (lowpower_timer_mode == `ELOP_MD_START);
            grp_in_evt_o <= edge_evt;
        end
    end

    assign idx = wb_adr_i[31:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr = req && wb_we_i && wb_sel_i[0] && hit;

    always @*
    begin
        hit = 1'b1;
        rd = 32'h00000000;
        if (idx == `ELOP_IDX_OPT_A)
            rd[7:0] = opt_a_r;
        else if (idx == `ELOP_IDX_OPT_B)
            rd[7:0] = opt_b_r;
        else if (idx == `ELOP_IDX_OPT_C)
            rd[7:0] = opt_c_r;
        else if (idx == `ELOP_IDX_OPT_D)
            rd[7:0] = opt_d_r;
        else if (idx == `ELOP_IDX_MEMBER)
            rd[PW-1:0] = member_r;
        else if (idx == `ELOP_IDX_GCTRL)
            rd[7:0] = gctrl_r;
        else if (idx == `ELOP_IDX_PBUF)
            rd[PW-1:0] = pbuf_r;
        else if (idx == `ELOP_IDX_PDIR)
            rd[PW-1:0] = port_direction_o;
        else if (idx == `ELOP_IDX_POUT)
            rd[PW-1:0] = port_output_data_o;
        else
            hit = 1'b0;
    end

    // port buffer: software write, then event latch of input pins wins
    always @*
    begin
        pbuf_nxt = pbuf_r;
        if (wr && idx == `ELOP_IDX_PBUF)
            pbuf_nxt = (pbuf_r & in_members) | (wb_dat_i[PW-1:0] & ~in_members);
        if (grp_in_evt_i && buffer_overwrite_enable)
            pbuf_nxt = (pbuf_nxt & ~in_members) | (port_pin_i & in_members);
    end

    // output group action on member output pins only
    always @*
    begin
        pout_nxt = port_output_data_o;
        if (wr && idx == `ELOP_IDX_POUT)
            pout_nxt = wb_dat_i[PW-1:0];
        if (grp_out_evt_i)
        begin
            if (group_output_action[2])
                pout_nxt = (port_output_data_o & ~out_members) |
                    (rot_grp(port_output_data_o, out_members) & out_members);
            else
            begin
                case (group_output_action)
                    `ELOP_ACT_LOW: pout_nxt = port_output_data_o & ~out_members;
                    `ELOP_ACT_HIGH: pout_nxt = port_output_data_o | out_members;
                    `ELOP_ACT_TOGGLE: pout_nxt = port_output_data_o ^ out_members;
                    default: pout_nxt = (port_output_data_o & ~out_members) |
                        (pbuf_r & out_members);
                endcase
            end
        end
    end

    // rotate among member bits only: each member takes the next higher member's value,
    // the lowest member's value wraps into the highest member
    function [PW-1:0] rot_grp;
        input [PW-1:0] d;
        input [PW-1:0] m;
        integer i;
        reg carry;
        reg seen;
        begin
            rot_grp = d;
            carry = 1'b0;
            seen = 1'b0;
            for (i = 0; i < PW; i = i + 1)
            begin
                if (m[i] && !seen)
                begin
                    carry = d[i];
                    seen = 1'b1;
                end
            end
            for (i = PW - 1; i >= 0; i = i - 1)
            begin
                if (m[i])
                begin
                    rot_grp[i] = carry;
                    carry = d[i];
                end
            end
        end
    endfunction

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            opt_a_r <= `ELOP_RST_OPT;
            opt_b_r <= `ELOP_RST_OPT;
            opt_c_r <= `ELOP_RST_OPT;
            opt_d_r <= `ELOP_RST_OPT;
            member_r <= {PW{1'b0}};
            gctrl_r <= `ELOP_RST_GC;
            pbuf_r <= {PW{1'b0}};
            port_output_data_o <= {PW{1'b0}};
            port_direction_o <= {PW{1'b0}};
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            wb_dat_o <= (req && hit && !wb_we_i) ? rd : 32'h00000000;
            if (wr && idx == `ELOP_IDX_OPT_A)
                opt_a_r <= wr_byte(opt_a_r, wb_dat_i[7:0], `ELOP_RSV_A);
            if (wr && idx == `ELOP_IDX_OPT_B)
                opt_b_r <= wr_byte(opt_b_r, wb_dat_i[7:0], `ELOP_RSV_B);
            if (wr && idx == `ELOP_IDX_OPT_C)
                opt_c_r <= wr_byte(opt_c_r, wb_dat_i[7:0], `ELOP_RSV_C);
            if (wr && idx == `ELOP_IDX_OPT_D)
                opt_d_r <= wr_byte(opt_d_r, wb_dat_i[7:0], `ELOP_RSV_D);
            if (wr && idx == `ELOP_IDX_MEMBER)
                member_r <= wb_dat_i[PW-1:0];
            if (wr && idx == `ELOP_IDX_GCTRL)
                gctrl_r <= wr_byte(gctrl_r, wb_dat_i[7:0], `ELOP_RSV_GC);
            if (wr && idx == `ELOP_IDX_PDIR)
                port_direction_o <= wb_dat_i[PW-1:0];
            pbuf_r <= pbuf_nxt;
            port_output_data_o <= pout_nxt;
        end
    end

endmodule

/* File: verif/elop_far_model.sv */
/*
 far side model: timer start bits and port B pins.
 assumes start pulses are one cycle wide; ext_i is what the outside drives.
*/
`timescale 1ns/1ps
module elop_far_model
#(
    parameter PW = 8
)
(
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] start_i,
    input wire [PW-1:0] pdir_i,
    input wire [PW-1:0] pout_i,
    input wire [PW-1:0] ext_i,
    output reg [3:0] run_o,
    output wire [PW-1:0] pin_o
);
    // a started timer keeps running, so later start events must be dropped
    always @(posedge clk_i)
    begin
        if (rst_i)
            run_o <= 4'h0;
        else
            run_o <= run_o | start_i;
    end
    assign pin_o = (pdir_i & pout_i) | (~pdir_i & ext_i);
endmodule

/* File: verif/elop_top_chk.sv */
/*
 checker for elop_top: bus answers, event decode timing, port changes.
 assumes it is bound to elop_top on one clock with a synchronous reset.
*/
`timescale 1ns/1ps
module elop_top_chk
#(
    parameter PW = 8
)
(
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire [3:0] mft_evt_i,
    input wire [3:0] mft_run_i,
    input wire lowpwr_evt_i,
    input wire grp_out_evt_i,
    input wire [3:0] mft_start_o,
    input wire [3:0] mft_restart_o,
    input wire [3:0] mft_capture_o,
    input wire lowpwr_irq_o,
    input wire [PW-1:0] port_output_data_o,
    input wire [PW-1:0] port_direction_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ans_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
        wb_ack_o || wb_err_o) else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data leaks");
    start_cause_a: assert property (mft_start_o[0] |-> $past(mft_evt_i[0], 2) &&
        !$past(mft_run_i[0], 2)) else $error("start without event or while running");
    one_act_a: assert property ($onehot0({mft_start_o[0], mft_restart_o[0],
        mft_capture_o[0]})) else $error("several actions from one event");
    cap_cause_a: assert property ((mft_capture_o & ~$past(mft_evt_i, 2)) == 4'h0)
        else $error("capture without event");
    irq_cause_a: assert property (lowpwr_irq_o |-> $past(lowpwr_evt_i))
        else $error("low power request without match");
    pout_cause_a: assert property (!$stable(port_output_data_o) |-> $past(grp_out_evt_i) ||
        $past(grp_out_evt_i, 2) || $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("port data changed without cause");
    dir_cause_a: assert property (!$stable(port_direction_o) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i)) else $error("direction changed without write");
endmodule

/* File: verif/elop_top_tb.sv */
/*
 testbench for elop_top: registers over wishbone, timer event decode, port group.
 assumes elop_far_model drives run bits and pins; elop_top_chk is bound below.
*/
`timescale 1ns/1ps
`include "elop_defines.vh"
`define CHK(a, e) \
    begin \
        check_count++; \
        if ((a) !== (e)) \
        begin \
            bad_count++; \
            $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
        end \
    end
module elop_top_tb;
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, cmt_evt_i, cmt_run_i;
    logic lowpwr_evt_i, grp_out_evt_i, grp_in_evt_i, cmt_start_o, cmt_restart_o, cmt_count_o;
    logic lowpwr_irq_o, grp_in_evt_o, er;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i, mft_evt_i, mft_run_i, mft_start_o, mft_restart_o, mft_capture_o;
    logic [1:0] bt_evt_i, bt_run_i, bt_start_o, bt_restart_o, bt_count_o, m;
    logic [7:0] port_pin_i, port_output_data_o, port_direction_o, ext, rd, po;
    logic [21:0] acc, ex;
    logic [31:0] ix [0:8];
    logic [7:0] rv [0:8];
    int bad_count, check_count, n, i;

    elop_top #(.PW(8)) uut (.*);
    elop_far_model #(.PW(8)) far (.clk_i(clk_i), .rst_i(rst_i), .start_i(mft_start_o),
        .pdir_i(port_direction_o), .pout_i(port_output_data_o), .ext_i(ext),
        .run_o(mft_run_i), .pin_o(port_pin_i));

    always #5 clk_i = ~clk_i;

    task automatic wb(input logic w, input logic [31:0] idx, input logic [7:0] d,
        input logic [3:0] s);
        begin
            @(posedge clk_i);
            wb_we_i <= w;
            wb_adr_i <= idx << 2;
            wb_dat_i <= {24'h0, d};
            wb_sel_i <= s;
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            do
                @(posedge clk_i);
            while (!(wb_ack_o || wb_err_o));
            rd = wb_dat_o[7:0];
            er = wb_err_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask

    task automatic wr(input logic [31:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'h1);
    endtask

    task automatic rc(input logic [31:0] idx, input logic [7:0] e);
        begin
            wb(1'b0, idx, 8'h00, 4'hF);
            `CHK(rd, e)
        end
    endtask

    // outputs are or-ed over a window so the exact pulse cycle does not matter
    task automatic fire(input logic [9:0] v);
        begin
            acc = 22'h0;
            @(posedge clk_i);
            {mft_evt_i, cmt_evt_i, lowpwr_evt_i, bt_evt_i, grp_out_evt_i, grp_in_evt_i} <= v;
            @(posedge clk_i);
            {mft_evt_i, cmt_evt_i, lowpwr_evt_i, bt_evt_i, grp_out_evt_i, grp_in_evt_i} <= 10'h0;
            repeat (4)
            begin
                @(posedge clk_i);
                acc = acc | {mft_start_o, mft_restart_o, mft_capture_o, cmt_start_o,
                    cmt_restart_o, cmt_count_o, lowpwr_irq_o, bt_start_o, bt_restart_o, bt_count_o};
            end
        end
    endtask

    task automatic edges(input logic [7:0] p);
        begin
            @(posedge clk_i);
            ext <= p;
            repeat (4)
            begin
                @(posedge clk_i);
                n = n + grp_in_evt_o;
            end
        end
    endtask

    task end_of_test;
        begin
            if (bad_count == 0 && check_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    initial
    begin
        #200000;
        bad_count++;
        end_of_test;
    end

    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {wb_we_i, wb_cyc_i, wb_stb_i, cmt_evt_i, cmt_run_i, lowpwr_evt_i} = 6'h0;
        {grp_out_evt_i, grp_in_evt_i, mft_evt_i, bt_evt_i, bt_run_i} = 10'h0;
        {wb_adr_i, wb_dat_i, wb_sel_i, ext} = 76'h0;
        ix = '{`ELOP_IDX_OPT_A, `ELOP_IDX_OPT_B, `ELOP_IDX_OPT_C, `ELOP_IDX_OPT_D,
            `ELOP_IDX_MEMBER, `ELOP_IDX_GCTRL, `ELOP_IDX_PBUF, `ELOP_IDX_PDIR, `ELOP_IDX_POUT};
        rv = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, `ELOP_RST_GC, 8'h00, 8'h00, 8'h00};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 9; i++)
            rc(ix[i], rv[i]);
        rv = '{`ELOP_RSV_A, `ELOP_RSV_B, `ELOP_RSV_C, `ELOP_RSV_D, 8'h00, `ELOP_RSV_GC,
            8'h00, 8'h00, 8'h00};
        for (i = 0; i < 9; i++)
        begin
            wr(ix[i], 8'h00);
            rc(ix[i], rv[i]);
        end
        wb(1'b1, `ELOP_IDX_MEMBER, 8'hFF, 4'hE);
        rc(`ELOP_IDX_MEMBER, 8'h00);
        wb(1'b0, 32'h0008B124, 8'h00, 4'hF);
        `CHK(er, 1'b1)
        // start mode runs last, twice: the second event must find the four mft timers running
        for (i = 0; i < 5; i++)
        begin
            m = (i > 3) ? 2'h0 : 2'(i + 1);
            wr(`ELOP_IDX_OPT_A, {m, m, m, 2'h3});
            wr(`ELOP_IDX_OPT_B, {6'h3F, m});
            wr(`ELOP_IDX_OPT_C, {4'hF, m, 2'h3});
            wr(`ELOP_IDX_OPT_D, {2'h3, m, 2'h3, m});
            fire(10'h3EC);
            ex = {{4{m == 0 && i < 4}}, {4{m == 1}}, {4{m == 2}}, m == 0, m == 1, m == 2,
                1'b0, {2{m == 0}}, {2{m == 1}}, {2{m == 2}}};
            `CHK(acc, ex)
        end
        wr(`ELOP_IDX_OPT_C, 8'hCF);
        fire(10'h010);
        `CHK(acc, 22'h000040)
        wr(`ELOP_IDX_OPT_C, 8'hFF);
        fire(10'h010);
        `CHK(acc, 22'h000000)
        wr(`ELOP_IDX_PDIR, 8'hFF);
        wr(`ELOP_IDX_MEMBER, 8'h0F);
        wr(`ELOP_IDX_POUT, 8'hA5);
        wr(`ELOP_IDX_PBUF, 8'h3C);
        po = 8'hA5;
        for (i = 0; i < 5; i++)
        begin
            wr(`ELOP_IDX_GCTRL, {1'h1, 3'(i), 4'h8});
            fire(10'h002);
            case (i)
                0: po = po & 8'hF0;
                1: po = po | 8'h0F;
                2: po = po ^ 8'h0F;
                3: po = {po[7:4], 4'hC};
                default: po = {po[7:4], po[0], po[3:1]};
            endcase
            `CHK(port_output_data_o, po)
        end
        wr(`ELOP_IDX_PDIR, 8'h00);
        for (i = 0; i < 3; i++)
        begin
            wr(`ELOP_IDX_GCTRL, 8'h88 | 8'(i));
            n = 0;
            edges(8'h81);
            edges(8'h00);
            `CHK(n, (i == 2) ? 2 : 1)
        end
        wr(`ELOP_IDX_GCTRL, 8'h8C);
        ext <= 8'h5A;
        fire(10'h001);
        rc(`ELOP_IDX_PBUF, 8'h3A);
        wr(`ELOP_IDX_GCTRL, 8'h88);
        ext <= 8'h05;
        fire(10'h001);
        rc(`ELOP_IDX_PBUF, 8'h3A);
        wr(`ELOP_IDX_PBUF, 8'hFF);
        rc(`ELOP_IDX_PBUF, 8'hFA);
        end_of_test;
    end
endmodule

bind elop_top elop_top_chk #(.PW(PW)) chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .mft_evt_i(mft_evt_i), .mft_run_i(mft_run_i),
    .lowpwr_evt_i(lowpwr_evt_i), .grp_out_evt_i(grp_out_evt_i), .mft_start_o(mft_start_o),
    .mft_restart_o(mft_restart_o), .mft_capture_o(mft_capture_o),
    .lowpwr_irq_o(lowpwr_irq_o), .port_output_data_o(port_output_data_o),
    .port_direction_o(port_direction_o));
